/* File: logic/pcie_credit_cfg.sv */
// Credit allocation, flow-control update scheduling and function 0 header setup behind a Wishbone slave.
//
// What this block does
// - Timer off: update per consumed TLP.
// - Timer on: updates at recommended interval.
// - Two-bit divider slows updates by 1,2,4,8.
// - Completion credits: EP-infinite, actual, or infinite.
// - Posted header credits 1 to 16.
// - Posted data credits 16 to 108.
// - Non-posted header credits 1 to 8.
// - Non-posted data credits 2 to 6.
// - Completion header credits 1 to 32.
// - Completion data credits 16 to 96.
// - Separate transmit allocation, same limits.
// - Function zero is always enabled.
// - Identifier reads return configured 16-bit values.
// - Revision read returns configured 8-bit value.
// - Class code read returns configured value.
// - Six BARs: enable, memory or I/O, prefetchable.
// - 64-bit BAR takes the next BAR too.
// - Resizable bit i advertises 2^(i+16) bytes.
// - BAR sizes are powers of two in range.
`timescale 1ns/10ps
`default_nettype none
module pcie_credit_cfg #(
	parameter int FC_BASE_CYC = pcie_cfg_pkg::FC_UPDATE_BASE_CYC
) (
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic I_ROOT_PORT,
	input wire logic I_RX_TLP_CONSUMED,
	output logic O_FC_UPDATE,
	output logic [7:0] O_ADV_PH,
	output logic [7:0] O_ADV_PD,
	output logic [7:0] O_ADV_NH,
	output logic [7:0] O_ADV_ND,
	output logic [7:0] O_ADV_CH,
	output logic [7:0] O_ADV_CD,
	input wire logic I_CFG_RD,
	input wire logic [5:0] I_CFG_DWORD,
	output logic [31:0] O_CFG_DAT,
	output logic O_CFG_VALID
);
	localparam int NUM_B = pcie_cfg_pkg::NUM_BARS;

	logic [31:0] ctrl_reg;
	logic [31:0] crd_reg [6];
	logic [31:0] id1_reg;
	logic [31:0] id2_reg;
	logic [31:0] id3_reg;
	logic rbar_on_reg;
	logic [31:0] bar_reg [NUM_B];
	logic [31:0] sizes_reg [NUM_B];
	logic reject_reg;
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_mux;
	logic [31:0] wr_val;
	logic [31:0] byte_mask;
	logic wr_ok;
	logic [2:0] bar_idx;
	logic bar_hit;
	logic [1:0] cpl_sel;
	logic cpl_inf;

	////////////////////////////////////////////////////////////////////////////
	// Field checks.

	function automatic logic credits_ok(input logic [31:0] v, input logic [7:0] hmin, input logic [7:0] hmax,
		input logic [7:0] dmin, input logic [7:0] dmax, input logic [15:0] hbytes, input logic [15:0] ram);
		logic [7:0] h;
		logic [7:0] d;
		logic [15:0] total;
		h = v[pcie_cfg_pkg::CRD_HDR_LSB +: 8];
		d = v[pcie_cfg_pkg::CRD_DAT_LSB +: 8];
		total = 16'(16'(h) * hbytes) + 16'(16'(d) * pcie_cfg_pkg::BYTES_DATA);
		credits_ok = h >= hmin && h <= hmax && d >= dmin && d <= dmax && total <= ram;
	endfunction

	function automatic logic bar_ok(input logic [31:0] v, input logic [2:0] idx);
		logic [5:0] sz;
		sz = v[pcie_cfg_pkg::BAR_SIZE_LSB +: 6];
		if (!v[pcie_cfg_pkg::BAR_EN_BIT]) begin
			bar_ok = 1'b1;
		end else if (v[pcie_cfg_pkg::BAR_IO_BIT]) begin
			bar_ok = !v[pcie_cfg_pkg::BAR_64_BIT] && !v[pcie_cfg_pkg::BAR_PREF_BIT]
				&& sz >= pcie_cfg_pkg::SZ_IO_MIN && sz <= pcie_cfg_pkg::SZ_IO_MAX;
		end else if (v[pcie_cfg_pkg::BAR_64_BIT]) begin
			bar_ok = idx != 3'(NUM_B - 1) && sz >= pcie_cfg_pkg::SZ_MEM64_MIN
				&& sz <= pcie_cfg_pkg::SZ_MEM64_MAX;
		end else begin
			bar_ok = sz >= pcie_cfg_pkg::SZ_MEM32_MIN && sz <= pcie_cfg_pkg::SZ_MEM32_MAX;
		end
	endfunction

	// A BAR is hidden when the BAR below it is an enabled 64-bit memory BAR.
	function automatic logic bar_hidden(input int i);
		if (i == 0) begin
			bar_hidden = 1'b0;
		end else begin
			bar_hidden = bar_reg[i-1][pcie_cfg_pkg::BAR_EN_BIT] && !bar_reg[i-1][pcie_cfg_pkg::BAR_IO_BIT]
				&& bar_reg[i-1][pcie_cfg_pkg::BAR_64_BIT];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack for one cycle.

	assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	assign wb_wr = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK;
	assign bar_idx = 3'((I_WB_ADR - pcie_cfg_pkg::OFF_BAR0) >> 2);
	assign bar_hit = bar_idx < 3'(NUM_B);

	always_comb begin
		byte_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
		if (I_WB_ADR == pcie_cfg_pkg::OFF_CTRL) begin
			rd_mux = ctrl_reg;
		end else if (I_WB_ADR >= pcie_cfg_pkg::OFF_RX_P && I_WB_ADR <= pcie_cfg_pkg::OFF_TX_C
			&& I_WB_ADR[1:0] == 2'h0) begin
			rd_mux = crd_reg[3'((I_WB_ADR - pcie_cfg_pkg::OFF_RX_P) >> 2)];
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID1) begin
			rd_mux = id1_reg;
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID2) begin
			rd_mux = id2_reg;
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID3) begin
			rd_mux = id3_reg;
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_RBAR) begin
			rd_mux = {31'h0000_0000, rbar_on_reg};
		end else if (I_WB_ADR >= pcie_cfg_pkg::OFF_BAR0 && I_WB_ADR < pcie_cfg_pkg::OFF_SIZES0
			&& I_WB_ADR[1:0] == 2'h0) begin
			rd_mux = bar_reg[bar_idx];
		end else if (I_WB_ADR >= pcie_cfg_pkg::OFF_SIZES0 && I_WB_ADR < pcie_cfg_pkg::OFF_STATUS
			&& I_WB_ADR[1:0] == 2'h0) begin
			rd_mux = sizes_reg[3'((I_WB_ADR - pcie_cfg_pkg::OFF_SIZES0) >> 2)];
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_STATUS) begin
			// Bit 1 is the function 0 disable flag, fixed off.
			rd_mux = {30'h0000_0000, 1'b0, reject_reg};
		end else begin
			rd_mux = 32'h0000_0000;
		end
		wr_val = (rd_mux & ~byte_mask) | (I_WB_DAT & byte_mask);
	end

	// Out-of-range values are refused whole, so the block never runs on a half-valid allocation.
	always_comb begin
		if (I_WB_ADR == pcie_cfg_pkg::OFF_CTRL) begin
			wr_ok = wr_val[pcie_cfg_pkg::CTRL_SEL_LSB +: 2] <= pcie_cfg_pkg::CPL_ADV_INFINITE;
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_RX_P || I_WB_ADR == pcie_cfg_pkg::OFF_TX_P) begin
			wr_ok = credits_ok(wr_val, pcie_cfg_pkg::PH_MIN, pcie_cfg_pkg::PH_MAX, pcie_cfg_pkg::PD_MIN,
				pcie_cfg_pkg::PD_MAX, pcie_cfg_pkg::BYTES_PN_HDR, pcie_cfg_pkg::RAM_P_BYTES);
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_RX_N || I_WB_ADR == pcie_cfg_pkg::OFF_TX_N) begin
			wr_ok = credits_ok(wr_val, pcie_cfg_pkg::NH_MIN, pcie_cfg_pkg::NH_MAX, pcie_cfg_pkg::ND_MIN,
				pcie_cfg_pkg::ND_MAX, pcie_cfg_pkg::BYTES_PN_HDR, pcie_cfg_pkg::RAM_N_BYTES);
		end else if (I_WB_ADR == pcie_cfg_pkg::OFF_RX_C || I_WB_ADR == pcie_cfg_pkg::OFF_TX_C) begin
			wr_ok = credits_ok(wr_val, pcie_cfg_pkg::CH_MIN, pcie_cfg_pkg::CH_MAX, pcie_cfg_pkg::CD_MIN,
				pcie_cfg_pkg::CD_MAX, pcie_cfg_pkg::BYTES_CPL_HDR, pcie_cfg_pkg::RAM_C_BYTES);
		end else if (I_WB_ADR >= pcie_cfg_pkg::OFF_BAR0 && I_WB_ADR < pcie_cfg_pkg::OFF_SIZES0) begin
			wr_ok = bar_ok(wr_val, bar_idx);
		end else begin
			wr_ok = 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h0000_0000;
		end else begin
			O_WB_ACK <= wb_req;
			O_WB_DAT <= wb_req ? rd_mux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register storage; writes land on the edge at which the master samples ack, while the request still stands.

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			ctrl_reg <= pcie_cfg_pkg::CTRL_RESET;
			id1_reg <= pcie_cfg_pkg::ID1_RESET;
			id2_reg <= pcie_cfg_pkg::ID2_RESET;
			id3_reg <= pcie_cfg_pkg::ID3_RESET;
			rbar_on_reg <= 1'b0;
		end else if (wb_wr && wr_ok) begin
			if (I_WB_ADR == pcie_cfg_pkg::OFF_CTRL) begin
				ctrl_reg <= wr_val & 32'h0000_001F;
			end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID1) begin
				id1_reg <= wr_val;
			end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID2) begin
				id2_reg <= wr_val;
			end else if (I_WB_ADR == pcie_cfg_pkg::OFF_ID3) begin
				id3_reg <= wr_val;
			end else if (I_WB_ADR == pcie_cfg_pkg::OFF_RBAR) begin
				rbar_on_reg <= wr_val[0];
			end
		end
	end

	// Receive allocations are entries 0..2, transmit allocations 3..5.
	generate
		for (genvar k = 0; k < 6; k++) begin : g_crd
			localparam logic [31:0] RST = (k % 3 == 0) ? pcie_cfg_pkg::CRD_P_RESET :
				(k % 3 == 1) ? pcie_cfg_pkg::CRD_N_RESET : pcie_cfg_pkg::CRD_C_RESET;
			always_ff @(posedge I_CLK) begin
				if (I_SRST) begin
					crd_reg[k] <= RST;
				end else if (wb_wr && wr_ok && I_WB_ADR == 8'(pcie_cfg_pkg::OFF_RX_P + 8'(4 * k))) begin
					crd_reg[k] <= wr_val & 32'h00FF_00FF;
				end
			end
		end
		for (genvar b = 0; b < NUM_B; b++) begin : g_bar
			always_ff @(posedge I_CLK) begin
				if (I_SRST) begin
					bar_reg[b] <= pcie_cfg_pkg::BAR_RESET;
					sizes_reg[b] <= 32'h0000_0000;
				end else if (wb_wr && wr_ok) begin
					if (I_WB_ADR == 8'(pcie_cfg_pkg::OFF_BAR0 + 8'(4 * b))) begin
						bar_reg[b] <= wr_val & 32'h0000_3F1F;
					end
					if (I_WB_ADR == 8'(pcie_cfg_pkg::OFF_SIZES0 + 8'(4 * b))) begin
						sizes_reg[b] <= wr_val & pcie_cfg_pkg::SIZES_MASK;
					end
				end
			end
		end
	endgenerate

	// A refused write sets the flag; writing one clears it, but a new refusal in that cycle wins.
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			reject_reg <= 1'b0;
		end else if (wb_wr && !wr_ok) begin
			reject_reg <= 1'b1;
		end else if (wb_wr && I_WB_ADR == pcie_cfg_pkg::OFF_STATUS && I_WB_SEL[0] && I_WB_DAT[0]) begin
			reject_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Credit advertisement and flow-control updates.

	assign cpl_sel = ctrl_reg[pcie_cfg_pkg::CTRL_SEL_LSB +: 2];
	assign cpl_inf = cpl_sel == pcie_cfg_pkg::CPL_ADV_INFINITE
		|| (cpl_sel == pcie_cfg_pkg::CPL_ADV_EP_INF && !I_ROOT_PORT);

	// Zero is the infinite credit encoding on the link.
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_ADV_PH <= pcie_cfg_pkg::CRD_P_RESET[7:0];
			O_ADV_PD <= pcie_cfg_pkg::CRD_P_RESET[23:16];
			O_ADV_NH <= pcie_cfg_pkg::CRD_N_RESET[7:0];
			O_ADV_ND <= pcie_cfg_pkg::CRD_N_RESET[23:16];
			O_ADV_CH <= 8'h00;
			O_ADV_CD <= 8'h00;
		end else begin
			O_ADV_PH <= crd_reg[0][7:0];
			O_ADV_PD <= crd_reg[0][23:16];
			O_ADV_NH <= crd_reg[1][7:0];
			O_ADV_ND <= crd_reg[1][23:16];
			O_ADV_CH <= cpl_inf ? 8'h00 : crd_reg[2][7:0];
			O_ADV_CD <= cpl_inf ? 8'h00 : crd_reg[2][23:16];
		end
	end

	fc_update_sched #(
		.BASE_CYC(FC_BASE_CYC)
	) u_sched (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_timer_dis(ctrl_reg[pcie_cfg_pkg::CTRL_TMR_DIS_BIT]),
		.i_div(ctrl_reg[pcie_cfg_pkg::CTRL_DIV_LSB +: 2]),
		.i_consumed(I_RX_TLP_CONSUMED),
		.o_update(O_FC_UPDATE)
	);

	////////////////////////////////////////////////////////////////////////////
	// Function 0 configuration reads, answered one cycle later.

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_CFG_VALID <= 1'b0;
			O_CFG_DAT <= 32'h0000_0000;
		end else begin
			O_CFG_VALID <= I_CFG_RD;
			O_CFG_DAT <= 32'h0000_0000;
			if (I_CFG_RD) begin
				if (I_CFG_DWORD == pcie_cfg_pkg::CFG_DW_ID) begin
					O_CFG_DAT <= id1_reg;
				end else if (I_CFG_DWORD == pcie_cfg_pkg::CFG_DW_CLASS) begin
					O_CFG_DAT <= id3_reg;
				end else if (I_CFG_DWORD == pcie_cfg_pkg::CFG_DW_SUBSYS) begin
					O_CFG_DAT <= id2_reg;
				end
				for (int i = 0; i < NUM_B; i++) begin
					if (I_CFG_DWORD == 6'(pcie_cfg_pkg::CFG_DW_BAR0 + 6'(i)) && !bar_hidden(i)
						&& bar_reg[i][pcie_cfg_pkg::BAR_EN_BIT]) begin
						if (bar_reg[i][pcie_cfg_pkg::BAR_IO_BIT]) begin
							O_CFG_DAT <= 32'h0000_0001;
						end else begin
							O_CFG_DAT <= {28'h000_0000, bar_reg[i][pcie_cfg_pkg::BAR_PREF_BIT],
								bar_reg[i][pcie_cfg_pkg::BAR_64_BIT], 2'h0};
						end
					end
					if (I_CFG_DWORD == 6'(pcie_cfg_pkg::CFG_DW_RBAR0 + 6'(i)) && rbar_on_reg
						&& bar_reg[i][pcie_cfg_pkg::BAR_RSZ_BIT]) begin
						O_CFG_DAT <= sizes_reg[i];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_wb_ack_next: assert property (@(posedge I_CLK) disable iff (I_SRST)
		wb_req |=> O_WB_ACK) else $error("request not acknowledged next cycle");
	a_wb_ack_single: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_WB_ACK |=> !O_WB_ACK) else $error("ack held longer than one cycle");
	a_cpl_infinite: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpl_sel == pcie_cfg_pkg::CPL_ADV_INFINITE |=> O_ADV_CH == 8'h00 && O_ADV_CD == 8'h00)
		else $error("infinite completion credits not advertised");
	a_cpl_rp_actual: assert property (@(posedge I_CLK) disable iff (I_SRST)
		cpl_sel == pcie_cfg_pkg::CPL_ADV_EP_INF && I_ROOT_PORT |=> O_ADV_CH == $past(crd_reg[2][7:0]))
		else $error("root port did not advertise actual completion credits");
	a_p_alloc_fit: assert property (@(posedge I_CLK) disable iff (I_SRST)
		credits_ok(crd_reg[0], pcie_cfg_pkg::PH_MIN, pcie_cfg_pkg::PH_MAX, pcie_cfg_pkg::PD_MIN,
		pcie_cfg_pkg::PD_MAX, pcie_cfg_pkg::BYTES_PN_HDR, pcie_cfg_pkg::RAM_P_BYTES))
		else $error("posted allocation out of range");
	a_n_alloc_fit: assert property (@(posedge I_CLK) disable iff (I_SRST)
		credits_ok(crd_reg[4], pcie_cfg_pkg::NH_MIN, pcie_cfg_pkg::NH_MAX, pcie_cfg_pkg::ND_MIN,
		pcie_cfg_pkg::ND_MAX, pcie_cfg_pkg::BYTES_PN_HDR, pcie_cfg_pkg::RAM_N_BYTES))
		else $error("transmit non-posted allocation out of range");
	a_bad_write_kept: assert property (@(posedge I_CLK) disable iff (I_SRST)
		wb_wr && !wr_ok && I_WB_ADR == pcie_cfg_pkg::OFF_RX_P |=> $stable(crd_reg[0]) && reject_reg)
		else $error("refused write changed an allocation");
	a_fn0_always_on: assert property (@(posedge I_CLK) disable iff (I_SRST)
		wb_req && I_WB_ADR == pcie_cfg_pkg::OFF_STATUS |=> O_WB_ACK && !O_WB_DAT[1])
		else $error("function 0 reported disabled");
	a_cfg_ident: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_CFG_RD && I_CFG_DWORD == pcie_cfg_pkg::CFG_DW_ID |=> O_CFG_VALID && O_CFG_DAT == $past(id1_reg))
		else $error("identifier read mismatch");
	a_bar64_upper: assert property (@(posedge I_CLK) disable iff (I_SRST)
		I_CFG_RD && I_CFG_DWORD == pcie_cfg_pkg::CFG_DW_BAR0 + 6'h01 && bar_hidden(1) |=> O_CFG_DAT == 32'h0)
		else $error("upper half of 64-bit BAR reads as its own BAR");
endmodule
`default_nettype wire

/* File: inc/pcie_cfg_pkg.sv */
// Register map, field layout, credit limits and timing constants of the credit and header setup block.
package pcie_cfg_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RX_P = 8'h04;
	localparam logic [7:0] OFF_RX_N = 8'h08;
	localparam logic [7:0] OFF_RX_C = 8'h0C;
	localparam logic [7:0] OFF_TX_P = 8'h10;
	localparam logic [7:0] OFF_TX_N = 8'h14;
	localparam logic [7:0] OFF_TX_C = 8'h18;
	localparam logic [7:0] OFF_ID1 = 8'h1C;
	localparam logic [7:0] OFF_ID2 = 8'h20;
	localparam logic [7:0] OFF_ID3 = 8'h24;
	localparam logic [7:0] OFF_RBAR = 8'h28;
	localparam logic [7:0] OFF_BAR0 = 8'h2C;
	localparam logic [7:0] OFF_SIZES0 = 8'h44;
	localparam logic [7:0] OFF_STATUS = 8'h5C;
	localparam int NUM_BARS = 6;

	// Control register fields.
	localparam int CTRL_TMR_DIS_BIT = 0;
	localparam int CTRL_DIV_LSB = 1;
	localparam int CTRL_SEL_LSB = 3;
	localparam logic [1:0] CPL_ADV_EP_INF = 2'h0;
	localparam logic [1:0] CPL_ADV_ACTUAL = 2'h1;
	localparam logic [1:0] CPL_ADV_INFINITE = 2'h2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Credit register fields: header count low byte, data count in byte two.
	localparam int CRD_HDR_LSB = 0;
	localparam int CRD_DAT_LSB = 16;

	// Credit ranges, bytes per credit and storage sizes.
	localparam logic [7:0] PH_MIN = 8'h01;
	localparam logic [7:0] PH_MAX = 8'h10;
	localparam logic [7:0] PD_MIN = 8'h10;
	localparam logic [7:0] PD_MAX = 8'h6C;
	localparam logic [7:0] NH_MIN = 8'h01;
	localparam logic [7:0] NH_MAX = 8'h08;
	localparam logic [7:0] ND_MIN = 8'h02;
	localparam logic [7:0] ND_MAX = 8'h06;
	localparam logic [7:0] CH_MIN = 8'h01;
	localparam logic [7:0] CH_MAX = 8'h20;
	localparam logic [7:0] CD_MIN = 8'h10;
	localparam logic [7:0] CD_MAX = 8'h60;
	localparam logic [15:0] BYTES_PN_HDR = 16'h0014;
	localparam logic [15:0] BYTES_CPL_HDR = 16'h0010;
	localparam logic [15:0] BYTES_DATA = 16'h0010;
	localparam logic [15:0] RAM_P_BYTES = 16'h0800;
	localparam logic [15:0] RAM_N_BYTES = 16'h0100;
	localparam logic [15:0] RAM_C_BYTES = 16'h0800;

	// Credit reset values: the largest counts that fill each storage RAM exactly.
	localparam logic [31:0] CRD_P_RESET = 32'h006C_0010;
	localparam logic [31:0] CRD_N_RESET = 32'h0006_0008;
	localparam logic [31:0] CRD_C_RESET = 32'h0060_0020;

	// Identity reset values.
	localparam logic [31:0] ID1_RESET = 32'hFFFF_FFFF;
	localparam logic [31:0] ID2_RESET = 32'hFFFF_FFFF;
	localparam logic [31:0] ID3_RESET = 32'hFFFF_FFFF;

	// BAR configuration fields; size is log2 of bytes.
	localparam int BAR_EN_BIT = 0;
	localparam int BAR_IO_BIT = 1;
	localparam int BAR_64_BIT = 2;
	localparam int BAR_PREF_BIT = 3;
	localparam int BAR_RSZ_BIT = 4;
	localparam int BAR_SIZE_LSB = 8;
	localparam logic [5:0] SZ_MEM32_MIN = 6'h04;
	localparam logic [5:0] SZ_MEM32_MAX = 6'h1F;
	localparam logic [5:0] SZ_MEM64_MIN = 6'h20;
	localparam logic [5:0] SZ_MEM64_MAX = 6'h3F;
	localparam logic [5:0] SZ_IO_MIN = 6'h01;
	localparam logic [5:0] SZ_IO_MAX = 6'h08;
	localparam logic [31:0] BAR_RESET = 32'h0000_0000;
	localparam logic [31:0] SIZES_MASK = 32'h00FF_FFF0;

	// Configuration space dword indices.
	localparam logic [5:0] CFG_DW_ID = 6'h00;
	localparam logic [5:0] CFG_DW_CLASS = 6'h02;
	localparam logic [5:0] CFG_DW_BAR0 = 6'h04;
	localparam logic [5:0] CFG_DW_SUBSYS = 6'h0B;
	localparam logic [5:0] CFG_DW_RBAR0 = 6'h10;

	// Flow-control update timing.
	localparam int CLK_PERIOD_NS = 100;
	localparam int FC_UPDATE_INTERVAL_NS = 30000;
	localparam int FC_UPDATE_BASE_CYC = FC_UPDATE_INTERVAL_NS / CLK_PERIOD_NS;

endpackage

/* File: logic/fc_update_sched.sv */
// Flow-control update scheduler: per consumed TLP or on a divided interval timer.
`timescale 1ns/10ps
`default_nettype none
module fc_update_sched #(
	parameter int BASE_CYC = pcie_cfg_pkg::FC_UPDATE_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_timer_dis,
	input wire logic [1:0] i_div,
	input wire logic i_consumed,
	output logic o_update
);
	logic [15:0] period;
	logic [15:0] cnt_reg;
	logic [15:0] gap_reg;
	logic [1:0] div_reg;
	logic steady_reg;

	// Dividing the update frequency stretches the interval by 1, 2, 4 or 8.
	assign period = 16'(BASE_CYC) << i_div;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_reg <= 16'h0000;
		end else if (i_timer_dis || cnt_reg >= period - 16'h0001) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_update <= 1'b0;
		end else if (i_timer_dis) begin
			o_update <= i_consumed;
		end else begin
			o_update <= (cnt_reg >= period - 16'h0001);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst || o_update) begin
			gap_reg <= 16'h0000;
		end else if (gap_reg != 16'hFFFF) begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end

	// Only a pulse that follows a full interval under unchanged settings is measured.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			div_reg <= 2'h0;
			steady_reg <= 1'b0;
		end else begin
			div_reg <= i_div;
			if (i_timer_dis || i_div != div_reg) begin
				steady_reg <= 1'b0;
			end else if (o_update) begin
				steady_reg <= 1'b1;
			end
		end
	end

	a_fc_on_consume: assert property (@(posedge i_clk) disable iff (i_srst)
		i_timer_dis && i_consumed |=> o_update) else $error("consumed TLP gave no update");
	a_fc_no_spurious: assert property (@(posedge i_clk) disable iff (i_srst)
		i_timer_dis && !i_consumed |=> !o_update) else $error("update without consumed TLP");
	a_fc_timer_gap: assert property (@(posedge i_clk) disable iff (i_srst)
		steady_reg && !i_timer_dis && i_div == div_reg && o_update
		|-> gap_reg == period - 16'h0001) else $error("timer update interval wrong");
endmodule
`default_nettype wire

/* File: verif/link_partner_model.sv */
// Link partner model: consumes received TLPs on request and counts flow-control updates.
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_go,
	input wire logic i_fc_update,
	output logic o_consumed,
	output logic [7:0] o_updates
);
	// One consumed TLP per cycle of request, so a held request gives back-to-back pulses.
	always_ff @(posedge i_clk) begin
		o_consumed <= i_go & ~i_srst;
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_updates <= 8'h00;
		end else if (i_fc_update) begin
			o_updates <= o_updates + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: verif/test_pcie_credit_cfg.sv */
// Self-checking bench for the credit and header setup block.
`timescale 1ns/10ps
`default_nettype none
module test_pcie_credit_cfg;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
	typedef struct packed {logic [5:0] w; logic [31:0] e;} crow_s;
	logic clk, srst, cyc, stb, we, root, cfg_rd, go, ack, fc, cfg_v, cons;
	logic [7:0] adr, upd;
	logic [7:0] adv [6];
	logic [5:0] dw;
	logic [31:0] wdat, rdat, cdat, q;
	int g;
	int n_fail = 0;
	int comparisons = 0;
	// Accepted counts fit their storage RAM.
	row_s rows [22] = '{'{8'h04, 32'h0050_0008, 32'h0050_0008}, '{8'h04, 32'h0010_0011, 32'h0050_0008},
		'{8'h08, 32'h0004_0002, 32'h0004_0002}, '{8'h08, 32'h0007_0001, 32'h0004_0002},
		'{8'h0C, 32'h0060_0021, 32'h0060_0020}, '{8'h0C, 32'h0010_0001, 32'h0010_0001},
		'{8'h10, 32'h006C_0010, 32'h006C_0010}, '{8'h10, 32'h000F_0001, 32'h006C_0010},
		'{8'h14, 32'h0006_0008, 32'h0006_0008}, '{8'h18, 32'h0061_0001, 32'h0060_0020},
		'{8'h1C, 32'h1234_ABCD, 32'h1234_ABCD}, '{8'h20, 32'h5678_9ABC, 32'h5678_9ABC},
		'{8'h24, 32'hABCD_EF12, 32'hABCD_EF12}, '{8'h60, 32'h1111_1111, 32'h0000_0000},
		'{8'h2C, 32'h0000_2005, 32'h0000_2005}, '{8'h40, 32'h0000_2005, 32'h0000_0000},
		'{8'h34, 32'h0000_0803, 32'h0000_0803}, '{8'h38, 32'h0000_0C19, 32'h0000_0C19},
		'{8'h3C, 32'h0000_080B, 32'h0000_0000}, '{8'h28, 32'h0000_0001, 32'h0000_0001},
		'{8'h50, 32'hFFFF_FFFF, 32'h00FF_FFF0}, '{8'h00, 32'h0000_0018, 32'h0000_0000}};
	crow_s cr [10] = '{'{6'h00, 32'h1234_ABCD}, '{6'h02, 32'hABCD_EF12}, '{6'h0B, 32'h5678_9ABC},
		'{6'h04, 32'h4}, '{6'h05, 32'h0}, '{6'h06, 32'h1}, '{6'h07, 32'h8}, '{6'h08, 32'h0},
		'{6'h13, 32'h00FF_FFF0}, '{6'h10, 32'h0}};

	pcie_credit_cfg #(.FC_BASE_CYC(8)) uut (.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_ROOT_PORT(root), .I_RX_TLP_CONSUMED(cons), .O_FC_UPDATE(fc), .O_ADV_PH(adv[0]), .O_ADV_PD(adv[1]),
		.O_ADV_NH(adv[2]), .O_ADV_ND(adv[3]), .O_ADV_CH(adv[4]), .O_ADV_CD(adv[5]), .I_CFG_RD(cfg_rd),
		.I_CFG_DWORD(dw), .O_CFG_DAT(cdat), .O_CFG_VALID(cfg_v));
	link_partner_model partner (.i_clk(clk), .i_srst(srst), .i_go(go), .i_fc_update(fc), .o_consumed(cons),
		.o_updates(upd));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request is held until ack is sampled high, then released for at least one cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			wrap_up();
		end
	endtask

	task automatic wait_fc();
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while (fc !== 1'b1 && g < 3000);
		if (g >= 3000) begin
			n_fail++;
			wrap_up();
		end
	endtask

	task automatic adv_chk(input logic [31:0] e);
		chk("adv", {adv[0], adv[1], adv[2], adv[3]}, e);
	endtask

	initial begin
		{srst, cyc, stb, we, root, cfg_rd, go, adr, wdat, dw} = {7'h40, 8'h00, 32'h0, 6'h00};
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		adv_chk(32'h106C_0806);
		chk("adv_cpl", {adv[4], adv[5]}, 32'h0);
		wb(1'b0, 8'h5C, 32'h0);
		chk("status", q, 32'h0);
		for (int i = 0; i < 22; i++) begin
			wb(1'b1, rows[i].a, rows[i].d);
			wb(1'b0, rows[i].a, 32'h0);
			chk("reg", q, rows[i].e);
		end
		wb(1'b0, 8'h5C, 32'h0);
		chk("status", q, 32'h1);
		wb(1'b1, 8'h5C, 32'h1);
		wb(1'b0, 8'h5C, 32'h0);
		chk("status_clr", q, 32'h0);
		adv_chk(32'h0850_0204);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			cfg_rd <= 1'b1;
			dw <= cr[i].w;
			@(posedge clk);
			cfg_rd <= 1'b0;
			@(posedge clk);
			chk("cfg", cfg_v ? cdat : 32'hDEAD_0000, cr[i].e);
		end
		for (int s = 0; s < 3; s++) begin
			for (int r = 0; r < 2; r++) begin
				root <= r[0];
				wb(1'b1, 8'h00, {27'h0, s[1:0], 3'h0});
				repeat (2) @(posedge clk);
				chk("adv_cpl", {adv[4], adv[5]}, (s == 2 || (s == 0 && r == 0)) ? 32'h0 : 32'h0110);
			end
		end
		for (int d = 0; d < 4; d++) begin
			wb(1'b1, 8'h00, {27'h1, d[1:0], 1'b0});
			// The first pulse may still follow the old divider, so the gap after it is measured.
			wait_fc();
			wait_fc();
			chk("fc_gap", g, 8 << d);
		end
		wb(1'b1, 8'h00, 32'h1);
		q = {24'h0, upd};
		go <= 1'b1;
		repeat (2) @(posedge clk);
		go <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			chk("fc_upd", {31'h0, fc}, (k < 2) ? 32'h1 : 32'h0);
		end
		@(posedge clk);
		chk("partner_upd", {24'h0, upd}, q + 32'h2);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		adv_chk(32'h106C_0806);
		wrap_up();
	end
endmodule
`default_nettype wire
